// ==== shared/lfs_pkg.sv ====
// holds the register map, command codes, field layouts and timing counts
// of the led fault status and lock flag block; assumes a 32-bit ahb-lite bus
package lfs_pkg;

  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] LFS_OFS_CMD = 8'h00; // command word, write only
  localparam logic [7:0] LFS_OFS_STAT1 = 8'h04; // fault and reset flags
  localparam logic [7:0] LFS_OFS_STAT2 = 8'h08; // five lock flags
  localparam logic [7:0] LFS_OFS_CTRL = 8'h0c; // control words 1 and 2
  localparam logic [7:0] LFS_OFS_DATA0 = 8'h10; // first protected data word
  localparam int LFS_DATA_WORDS = 12; // protected data words
  localparam logic [7:0] LFS_OFS_DATA_END = 8'h3c; // last protected word

  // ---------------------------------------------------------------------
  // protected data word indices
  // ---------------------------------------------------------------------
  localparam logic [3:0] LFS_IDX_CUR_LAST = 4'h2; // 0..2 current levels
  localparam logic [3:0] LFS_IDX_MASK_LAST = 4'h5; // 3..5 masks, voltage sel
  localparam logic [3:0] LFS_IDX_PCFG_LAST = 4'h8; // 6..8 pwm configuration
  localparam logic [3:0] LFS_IDX_DUTY_LAST = 4'hb; // 9..11 pwm duty values
  localparam logic [3:0] LFS_IDX_VSEL = 4'h5; // short detect voltage sel
  localparam logic [3:0] LFS_IDX_CHSEL_HI = 4'h7; // channel select outputs 9..12
  localparam logic [3:0] LFS_IDX_FRAME = 4'h8; // step count and frame freq

  // ---------------------------------------------------------------------
  // field masks of the protected words
  // ---------------------------------------------------------------------
  localparam logic [31:0] LFS_MSK_FULL = 32'hffffffff; // 4 x 8-bit current
  localparam logic [31:0] LFS_MSK_PAIR12 = 32'h0fff0fff; // two 12-bit masks
  localparam logic [31:0] LFS_MSK_VSEL = 32'h00ffffff; // 12 x 2-bit voltage
  localparam logic [31:0] LFS_MSK_CHSEL_LO = 32'h00ffffff; // 8 x 3-bit select
  localparam logic [31:0] LFS_MSK_CHSEL_HI = 32'h00000fff; // 4 x 3-bit select
  localparam logic [31:0] LFS_MSK_FRAME = 32'h0000003f; // step[1:0] freq[5:2]
  localparam logic [31:0] LFS_MSK_DUTY = 32'h03ff03ff; // two 10-bit duties
  localparam logic [31:0] LFS_MSK_CTRL = 32'h00003fff; // control bits 13:0

  // ---------------------------------------------------------------------
  // command codes, written to the low byte of the command word
  // ---------------------------------------------------------------------
  localparam logic [7:0] LFS_CMD_CLR_STATUS = 8'h01;
  localparam logic [7:0] LFS_CMD_CHECK_CLK = 8'h02;
  localparam logic [7:0] LFS_CMD_CLR_CLK = 8'h03;
  localparam logic [7:0] LFS_CMD_CLR_RESET = 8'h04;
  localparam logic [7:0] LFS_CMD_SW_RESET = 8'h05;
  localparam logic [7:0] LFS_CMD_LOCK_BASE = 8'h10; // +0 current .. +4 control
  localparam logic [7:0] LFS_CMD_UNLOCK_BASE = 8'h20; // same order as lock

  // ---------------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [31:0] LFS_RST_WORD = 32'h00000000;
  localparam int LFS_CLK_PERIOD_NS = 20; // 50 mhz system clock
  localparam int LFS_CLK_ABSENT_NS = 1000; // no edge for this long = absent
  localparam int LFS_CLK_ABSENT_CYC =
    (LFS_CLK_ABSENT_NS + LFS_CLK_PERIOD_NS - 1) / LFS_CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic resetOccurred; // bit 3
    logic clockAbsence; // bit 2
    logic supplyFault; // bit 1
    logic adjShort; // bit 0
  } lfs_status1_s;

  typedef struct packed {
    logic ctrl; // bit 4
    logic duty; // bit 3
    logic pwmCfg; // bit 2
    logic mask; // bit 1
    logic current; // bit 0
  } lfs_lock_s;

  typedef struct packed {
    logic [5:0] spare; // bits 13:8, kept for control word 2
    logic adjacentFaultReportMask; // bit 7
    logic resistorFaultReportMask; // bit 6
    logic faultPinConfig; // bit 5
    logic slewRateSel; // bit 4
    logic externalClockFreqSel; // bit 3
    logic clockSourceSelect; // bit 2
    logic thermalShutdownDisable; // bit 1
    logic controlWord1BitA; // bit 0
  } lfs_ctrl_s;

endpackage

// ==== logic/lfs_word_mem.sv ====
// small word memory for the protected control data
// assumes one write and one read port on the same clock, registered read
`timescale 1ns/1ps
module lfs_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 12,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH]; // storage words

  // ---------------------------------------------------------------------
  // storage, cleared by reset so every setting has a known value
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // ---------------------------------------------------------------------
  // registered read; a write to the same word forwards its new value
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // lfs_word_mem

// ==== logic/lfs_status_lock.sv ====
// fault status flags, clock monitor and write lock flags of a 12-output
// led driver, reached over an ahb-lite slave port
// assumes a single-master ahb-lite bus on clk; fault and clock pins are
// asynchronous and are synchronised here
//
// Overview of operation
// - adjacent short on any output sets sticky flag
// - power-on sets fault flags; clear command zeroes
// - abnormal supply monitor sets sticky supply flag
// - status word one returns four fault flags
// - source select picks oscillator or external clock
// - check command starts monitor; flag tracks absence
// - clear command zeroes clock flag; power-on sets
// - any system reset sets reset-occurred flag
// - only clear-reset command zeroes reset flag
// - current lock blocks 12 current level writes
// - mask lock blocks masks and voltage settings
// - pwm config lock blocks select, steps, frequency
// - duty lock blocks six pwm duty values
// - control lock blocks control words 1, 2
// - status word two returns five lock flags
// - every system reset clears all lock flags
// - over 150c without disable forces outputs off
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module lfs_status_lock #(
  parameter int OUTPUTS = 12,
  parameter int ABSENT_CYC = lfs_pkg::LFS_CLK_ABSENT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // fault and reset sources, asynchronous
  input wire logic [OUTPUTS-1:0] adjShortDetect,
  input wire logic supplyAbnormal,
  input wire logic over150cFlag,
  input wire logic voltageDetectReset,
  // clocks under watch, asynchronous
  input wire logic internalOscClk,
  input wire logic externalClk,
  // state toward the output stage
  output logic ledOutputsOff,
  output lfs_pkg::lfs_status1_s status1,
  output lfs_pkg::lfs_lock_s lockFlags,
  output lfs_pkg::lfs_ctrl_s ctrlWord
);
  import lfs_pkg::*;

  localparam int NSYNC = OUTPUTS + 5; // pins that pass the synchroniser
  localparam int CW = $clog2(ABSENT_CYC + 1); // absence counter width
  localparam logic [CW-1:0] ABSENT_MAX = CW'(ABSENT_CYC);

  // ---------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------
  // field mask of a protected word, so reserved bits always read zero
  function automatic logic [31:0] fieldMask(input logic [3:0] idx);
    logic [31:0] m;
    m = LFS_MSK_FULL;
    if (idx <= LFS_IDX_CUR_LAST) begin
      m = LFS_MSK_FULL;
    end else if (idx == LFS_IDX_VSEL) begin
      m = LFS_MSK_VSEL;
    end else if (idx <= LFS_IDX_MASK_LAST) begin
      m = LFS_MSK_PAIR12;
    end else if (idx == LFS_IDX_FRAME) begin
      m = LFS_MSK_FRAME;
    end else if (idx == LFS_IDX_CHSEL_HI) begin
      m = LFS_MSK_CHSEL_HI;
    end else if (idx <= LFS_IDX_PCFG_LAST) begin
      m = LFS_MSK_CHSEL_LO;
    end else begin
      m = LFS_MSK_DUTY;
    end
    return m;
  endfunction

  // true when the word's lock group is locked
  function automatic logic wordLocked(input logic [3:0] idx, input lfs_lock_s lk);
    logic r;
    r = 1'b0;
    if (idx <= LFS_IDX_CUR_LAST) begin
      r = lk.current;
    end else if (idx <= LFS_IDX_MASK_LAST) begin
      r = lk.mask;
    end else if (idx <= LFS_IDX_PCFG_LAST) begin
      r = lk.pwmCfg;
    end else begin
      r = lk.duty;
    end
    return r;
  endfunction

  // word index of a byte address inside the protected range
  function automatic logic [3:0] wordIndex(input logic [7:0] ofs);
    logic [7:0] d;
    d = ofs - LFS_OFS_DATA0;
    return d[5:2];
  endfunction

  // ---------------------------------------------------------------------
  // pin synchroniser, two flip-flops per pin
  // ---------------------------------------------------------------------
  logic [NSYNC-1:0] syncMeta; // first stage, read only by syncStable
  logic [NSYNC-1:0] syncStable; // second stage, the only one logic reads
  wire [NSYNC-1:0] pinsRaw = {externalClk, internalOscClk, voltageDetectReset,
                              over150cFlag, supplyAbnormal, adjShortDetect};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncMeta <= '0;
      syncStable <= '0;
    end else begin
      syncMeta <= pinsRaw;
      syncStable <= syncMeta;
    end
  end

  wire [OUTPUTS-1:0] adjSync = syncStable[OUTPUTS-1:0];
  wire supplySync = syncStable[OUTPUTS];
  wire hotSync = syncStable[OUTPUTS+1];
  wire vdetSync = syncStable[OUTPUTS+2];
  wire oscSync = syncStable[OUTPUTS+3];
  wire extSync = syncStable[OUTPUTS+4];

  // ---------------------------------------------------------------------
  // ahb-lite address phase capture
  // ---------------------------------------------------------------------
  logic dpValid; // a transfer is in its data phase
  logic dpWrite; // that transfer is a write
  logic [7:0] dpAddr; // its byte offset
  wire addrTake = hsel && htrans[1] && hready;
  wire [7:0] apAddr = haddr[7:0];
  wire apMapped = (haddr[31:8] == 24'h000000);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
    end else if (hready) begin
      dpValid <= addrTake && apMapped;
      dpWrite <= hwrite;
      dpAddr <= apAddr;
    end
  end

  // no wait states, every answer is okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------------
  // data phase decode
  // ---------------------------------------------------------------------
  wire dpWr = dpValid && dpWrite;
  wire dpDataSel = (dpAddr >= LFS_OFS_DATA0) && (dpAddr <= LFS_OFS_DATA_END);
  wire cmdStrobe = dpWr && (dpAddr == LFS_OFS_CMD);
  wire ctrlStrobe = dpWr && (dpAddr == LFS_OFS_CTRL);
  wire [7:0] cmdCode = hwdata[7:0];
  wire [3:0] dpIdx = wordIndex(dpAddr);

  // individual command pulses, one cycle each
  wire cmdClrStatus = cmdStrobe && (cmdCode == LFS_CMD_CLR_STATUS);
  wire cmdCheckClk = cmdStrobe && (cmdCode == LFS_CMD_CHECK_CLK);
  wire cmdClrClk = cmdStrobe && (cmdCode == LFS_CMD_CLR_CLK);
  wire cmdClrReset = cmdStrobe && (cmdCode == LFS_CMD_CLR_RESET);
  wire cmdSwReset = cmdStrobe && (cmdCode == LFS_CMD_SW_RESET);
  wire [4:0] cmdLock;
  wire [4:0] cmdUnlock;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gCmdLock
      assign cmdLock[g] = cmdStrobe && (cmdCode == LFS_CMD_LOCK_BASE + 8'(g));
      assign cmdUnlock[g] = cmdStrobe && (cmdCode == LFS_CMD_UNLOCK_BASE + 8'(g));
    end
  endgenerate

  // ---------------------------------------------------------------------
  // reset sources of the system
  // ---------------------------------------------------------------------
  logic hotPrev; // thermal shutdown level one cycle ago
  wire hotActive = hotSync && !ctrlWord.thermalShutdownDisable;
  wire hotRise = hotActive && !hotPrev;
  // voltage detect holds the block in power-on state while high
  wire powerOn = vdetSync;
  // software reset and thermal shutdown act for one cycle
  wire sysReset = powerOn || cmdSwReset || hotRise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hotPrev <= 1'b0;
      ledOutputsOff <= 1'b0;
    end else begin
      hotPrev <= hotActive;
      ledOutputsOff <= hotActive;
    end
  end

  // ---------------------------------------------------------------------
  // sticky fault flags
  // ---------------------------------------------------------------------
  // a fault present in the clear cycle wins, so no event is lost
  wire next_adjShort = powerOn ? 1'b1 :
                       (|adjSync) ? 1'b1 :
                       cmdClrStatus ? 1'b0 : status1.adjShort;
  wire next_supplyFault = powerOn ? 1'b1 :
                          supplySync ? 1'b1 :
                          cmdClrStatus ? 1'b0 : status1.supplyFault;
  // reset flag ignores the status clear; only the clear-reset command zeroes it
  wire next_resetOccurred = sysReset ? 1'b1 :
                            cmdClrReset ? 1'b0 : status1.resetOccurred;

  // ---------------------------------------------------------------------
  // clock monitor
  // ---------------------------------------------------------------------
  logic selPrev; // selected clock one cycle ago
  logic checkOn; // monitoring armed by the check command
  logic [CW-1:0] absentCnt; // cycles since the last rising edge
  // source select steers which clock is watched
  wire selClk = ctrlWord.clockSourceSelect ? extSync : oscSync;
  wire selEdge = selClk && !selPrev;
  wire clockMissing = (absentCnt == ABSENT_MAX);

  // counter saturates; a source switch may fake one edge, harmless
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selPrev <= 1'b0;
      absentCnt <= '0;
    end else begin
      selPrev <= selClk;
      if (selEdge || cmdCheckClk) begin
        absentCnt <= '0;
      end else if (!clockMissing) begin
        absentCnt <= absentCnt + CW'(1);
      end
    end
  end

  // arming follows the command; clear or power-on disarms
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      checkOn <= 1'b0;
    end else if (powerOn || cmdClrClk) begin
      checkOn <= 1'b0;
    end else if (cmdCheckClk) begin
      checkOn <= 1'b1;
    end
  end

  wire next_clockAbsence = powerOn ? 1'b1 :
                           cmdClrClk ? 1'b0 :
                           checkOn ? clockMissing :
                           status1.clockAbsence;

  // ---------------------------------------------------------------------
  // status register one
  // ---------------------------------------------------------------------
  // pin reset comes up with every flag raised
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status1 <= 4'hf;
    end else begin
      status1 <= {next_resetOccurred, next_clockAbsence,
                  next_supplyFault, next_adjShort};
    end
  end

  // ---------------------------------------------------------------------
  // lock flags
  // ---------------------------------------------------------------------
  lfs_lock_s next_lockFlags; // lock bits after this cycle's commands

  always_comb begin
    next_lockFlags = lockFlags;
    if (sysReset) begin
      next_lockFlags = '0;
    end else begin
      next_lockFlags = (lockFlags | cmdLock) & ~cmdUnlock;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockFlags <= '0;
    end else begin
      lockFlags <= next_lockFlags;
    end
  end

  // ---------------------------------------------------------------------
  // control words 1 and 2
  // ---------------------------------------------------------------------
  // lock drops the write but the bus transfer still completes
  wire ctrlWe = ctrlStrobe && !lockFlags.ctrl;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlWord <= lfs_ctrl_s'(LFS_RST_WORD[13:0]);
    end else if (ctrlWe) begin
      ctrlWord <= lfs_ctrl_s'(hwdata[13:0] & LFS_MSK_CTRL[13:0]);
    end
  end

  // ---------------------------------------------------------------------
  // protected data words
  // ---------------------------------------------------------------------
  wire dataWe = dpWr && dpDataSel && !wordLocked(dpIdx, lockFlags);
  wire [31:0] dataWdata = hwdata & fieldMask(dpIdx);
  wire apDataSel = (apAddr >= LFS_OFS_DATA0) && (apAddr <= LFS_OFS_DATA_END);
  wire [3:0] apIdx = apDataSel ? wordIndex(apAddr) : 4'h0;
  logic [31:0] memRdata; // word read during the address phase

  lfs_word_mem #(
    .WIDTH(32),
    .DEPTH(LFS_DATA_WORDS),
    .AW(4)
  ) u_lfs_word_mem (
    .clk(clk),
    .arst_n(arst_n),
    .we(dataWe),
    .waddr(dpIdx),
    .wdata(dataWdata),
    .raddr(apIdx),
    .rdata(memRdata)
  );

  // ---------------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------------
  logic [31:0] rdHold; // status or control word caught in address phase
  logic rdFromMem; // data phase reads the memory word
  wire [31:0] apRegData = (apAddr == LFS_OFS_STAT1) ? {28'h0, status1} :
                          (apAddr == LFS_OFS_STAT2) ? {27'h0, lockFlags} :
                          (apAddr == LFS_OFS_CTRL) ? {18'h0, ctrlWord} :
                          32'h00000000;

  // unmapped and write-only offsets read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdHold <= 32'h00000000;
      rdFromMem <= 1'b0;
    end else if (addrTake) begin
      rdHold <= apMapped ? apRegData : 32'h00000000;
      rdFromMem <= apMapped && apDataSel;
    end
  end

  assign hrdata = rdFromMem ? memRdata : rdHold;

endmodule // lfs_status_lock

// ==== tb/lfs_status_lock_sva.sv ====
// checker on the ports of the status and lock flag block
// assumes one-cycle data phases and pins synchronised in 3 edges
`timescale 1ns/1ps
module lfs_status_lock_sva
  import lfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and state
  input wire logic [11:0] adjShortDetect,
  input wire logic supplyAbnormal,
  input wire logic over150cFlag,
  input wire logic ledOutputsOff,
  input wire lfs_status1_s status1,
  input wire lfs_lock_s lockFlags,
  input wire lfs_ctrl_s ctrlWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------
  // write data phase tracking
  // ------
  logic wrPh; // a write is in its data phase
  logic [7:0] wrA; // its offset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPh <= 1'b0;
      wrA <= 8'h00;
    end else begin
      wrPh <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
      wrA <= haddr[7:0];
    end
  end
  wire cmdOn = wrPh && wrA == LFS_OFS_CMD; // command word being written
  wire [7:0] cmd = hwdata[7:0];
  wire lockCmd = cmdOn && (cmd[7:4] == 4'h1 || cmd[7:4] == 4'h2) && cmd[3:0] < 4'h5;
  // ------
  // properties
  // ------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_adj_set: assert property ((adjShortDetect != 12'h0) [*4] |-> status1.adjShort)
    else $error("adj flag not set");
  a_adj_sticky: assert property (status1.adjShort && !(cmdOn && cmd == LFS_CMD_CLR_STATUS)
    |=> status1.adjShort) else $error("adj flag dropped");
  a_supply_set: assert property (supplyAbnormal [*4] |-> status1.supplyFault)
    else $error("supply fault flag not set");
  a_rst_sticky: assert property (status1.resetOccurred && !(cmdOn && cmd == LFS_CMD_CLR_RESET)
    |=> status1.resetOccurred) else $error("reset flag dropped");
  a_lock_cmd: assert property (lockCmd |=> lockFlags[$past(cmd[2:0])] == $past(cmd[4]))
    else $error("lock flag wrong");
  a_swrst_locks: assert property (cmdOn && cmd == LFS_CMD_SW_RESET
    |=> lockFlags == 5'h00 && status1.resetOccurred) else $error("soft reset missed");
  a_ctrl_frozen: assert property (lockFlags.ctrl |=> $stable(ctrlWord))
    else $error("locked control changed");
  a_leds_off: assert property ((over150cFlag && !ctrlWord.thermalShutdownDisable) [*4]
    |-> ledOutputsOff) else $error("outputs not forced off");
  a_clk_clear: assert property (cmdOn && cmd == LFS_CMD_CLR_CLK |=> !status1.clockAbsence)
    else $error("clock flag not cleared");
endmodule // lfs_status_lock_sva

bind lfs_status_lock lfs_status_lock_sva u_lfs_status_lock_sva (.clk, .arst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .adjShortDetect, .supplyAbnormal,
  .over150cFlag, .ledOutputsOff, .status1, .lockFlags, .ctrlWord);

// ==== tb/lfs_host.sv ====
// host model: single-word ahb-lite master
// assumes the one slave's hreadyout is fed back as hready
`timescale 1ns/1ps
module lfs_host (
  // clock
  input wire logic clk,
  // master outputs
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one transfer; waits on hready with no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // lfs_host

// ==== tb/lfs_status_lock_tb.sv ====
// self-checking bench of the status and lock flag block
// assumes the host model and a shortened absence count
`timescale 1ns/1ps
module lfs_status_lock_tb;
  import lfs_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, oscOn = 1'b1, extOn = 1'b0;
  logic [11:0] adjShortDetect = 12'h0;
  logic supplyAbnormal = 1'b0, over150cFlag = 1'b0, voltageDetectReset = 1'b0;
  logic internalOscClk = 1'b0, externalClk = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, ledOutputsOff;
  logic [31:0] haddr, hwdata, hrdata, x, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  lfs_status1_s status1;
  lfs_lock_s lockFlags;
  lfs_ctrl_s ctrlWord;
  int nFail = 0, checkCount = 0;
  logic [7:0] la [5] = '{8'h10, 8'h1c, 8'h30, 8'h34, LFS_OFS_CTRL}; // one word per lock
  logic [31:0] lm [5] = '{LFS_MSK_FULL, LFS_MSK_PAIR12, LFS_MSK_FRAME, LFS_MSK_DUTY, LFS_MSK_CTRL};
  always #10 clk = ~clk;
  // watched clocks, offset from clk; external one idles low when off
  initial begin
    #3;
    fork
      forever #50 internalOscClk = oscOn ? ~internalOscClk : internalOscClk;
      forever #80 externalClk = extOn ? ~externalClk : 1'b0;
    join
  end
  lfs_host u_lfs_host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);
  lfs_status_lock #(.ABSENT_CYC(20)) u_lfs_status_lock (.clk, .arst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .adjShortDetect,
    .supplyAbnormal, .over150cFlag, .voltageDetectReset, .internalOscClk, .externalClk,
    .ledOutputsOff, .status1, .lockFlags, .ctrlWord);
  function automatic logic [31:0] st1(logic r, logic c, logic s, logic a);
    return {28'h0, r, c, s, a}; // status word one layout
  endfunction
  task automatic chk(logic [31:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_lfs_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    u_lfs_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(LFS_OFS_CMD, {24'h0, c});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    summarize();
  end
  initial begin
    void'($urandom(32'h3ddb));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(LFS_OFS_STAT1, st1(1, 1, 1, 1));
    rd(LFS_OFS_STAT2, 32'h0);
    cmd(LFS_CMD_CLR_STATUS);
    rd(LFS_OFS_STAT1, st1(1, 1, 0, 0));
    cmd(LFS_CMD_CLR_RESET);
    cmd(LFS_CMD_CLR_CLK);
    rd(LFS_OFS_STAT1, 32'h0);
    // sticky faults, random output and supply
    for (int k = 0; k < 4; k++) begin
      x = $urandom;
      x[8] = k[0]; // supply abnormal on alternate runs
      @(posedge clk) adjShortDetect <= 12'h1 << (x[7:0] % 12);
      supplyAbnormal <= x[8];
      repeat (5) @(posedge clk);
      adjShortDetect <= 12'h0;
      supplyAbnormal <= 1'b0;
      rd(LFS_OFS_STAT1, st1(0, 0, x[8], 1));
      cmd(LFS_CMD_CLR_STATUS);
      rd(LFS_OFS_STAT1, 32'h0);
    end
    // per lock: write, locked write dropped, unlock frees
    for (int i = 0; i < 5; i++) begin
      x = $urandom;
      wr(la[i], x);
      rd(la[i], x & lm[i]);
      cmd(LFS_CMD_LOCK_BASE + 8'(i));
      rd(LFS_OFS_STAT2, 32'h1 << i);
      wr(la[i], ~x);
      rd(la[i], x & lm[i]);
      cmd(LFS_CMD_UNLOCK_BASE + 8'(i));
      rd(LFS_OFS_STAT2, 32'h0);
      wr(la[i], ~x);
      rd(la[i], ~x & lm[i]);
    end
    for (int i = 0; i < 5; i++) cmd(LFS_CMD_LOCK_BASE + 8'(i));
    cmd(LFS_CMD_SW_RESET);
    rd(LFS_OFS_STAT2, 32'h0);
    rd(LFS_OFS_STAT1, st1(1, 0, 0, 0));
    cmd(LFS_CMD_CLR_RESET);
    // thermal shutdown, then disabled
    wr(LFS_OFS_CTRL, 32'h0);
    cmd(LFS_CMD_LOCK_BASE);
    @(posedge clk) over150cFlag <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, ledOutputsOff}, 32'h1);
    rd(LFS_OFS_STAT1, st1(1, 0, 0, 0));
    rd(LFS_OFS_STAT2, 32'h0);
    wr(LFS_OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, ledOutputsOff}, 32'h0);
    over150cFlag <= 1'b0;
    cmd(LFS_CMD_CLR_RESET);
    // clock monitor on each source
    for (int s = 0; s < 2; s++) begin
      wr(LFS_OFS_CTRL, s ? 32'h4 : 32'h0);
      extOn <= s[0];
      cmd(LFS_CMD_CHECK_CLK);
      repeat (40) @(posedge clk);
      rd(LFS_OFS_STAT1, 32'h0);
      if (s == 0) oscOn <= 1'b0;
      else extOn <= 1'b0;
      repeat (40) @(posedge clk);
      rd(LFS_OFS_STAT1, st1(0, 1, 0, 0));
    end
    cmd(LFS_CMD_CLR_CLK);
    rd(LFS_OFS_STAT1, 32'h0);
    // voltage-detect reset acts as power-on
    cmd(LFS_CMD_LOCK_BASE + 8'h3);
    @(posedge clk) voltageDetectReset <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(status1), st1(1, 1, 1, 1));
    chk(32'(lockFlags), 32'h0);
    voltageDetectReset <= 1'b0;
    repeat (4) @(posedge clk);
    // unmapped offset and the write-only command word
    wr(8'h40, $urandom);
    rd(8'h40, 32'h0);
    rd(LFS_OFS_CMD, 32'h0);
    summarize();
  end
endmodule // lfs_status_lock_tb
